// ==== include/lpe_map.svh ====
// register offsets, field positions and reset values of the leaf page entry decoder
// assumes a 32-bit register port with byte offsets on an 8-bit address
// Behaviour
// - For a 4-KByte leaf the page frame is entry bits host width minus one down to 12.
// - A translation request returns the transient-mapping bit 62 as the U field.
// - Without device-side translation caching, bit 62 is reserved and must be zero.
// - Without snoop control, the snoop-override bit 11 is reserved and must be zero.
// - Snoop-override set forces untranslated requests without PASID to snoop caches.
// - Translation requests without PASID return the snoop-override bit as the N field.
// - The snoop-override bit is disregarded for any request carrying a PASID.
// - Untranslated requests with a PASID always snoop processor caches.
// - Translation requests with a PASID always report N as 1.
// - The skip-attribute-table bit 6 is ignored while the memory-type enable is clear.
// - That bit only acts on nested PASID requests from coherent-domain devices.
// - Bit 6 clear uses the attribute table in the memory type; set leaves it out.
// - Memory type bits 5:3 decode 0 UC, 1 WC, 4 WT, 5 WP, 6 WB; others are reserved.
// - Write permission is refused when the entry write bit is zero.
// - Read permission is refused when the entry read bit is zero.
`ifndef LPE_MAP_SVH
`define LPE_MAP_SVH
`define LPE_REG_ENTRY_LO 8'h00
`define LPE_REG_ENTRY_HI 8'h04
`define LPE_REG_CONFIG   8'h08
`define LPE_REG_REQUEST  8'h0C
`define LPE_REG_STATUS   8'h10
`define LPE_REG_PHYS_LO  8'h14
`define LPE_REG_PHYS_HI  8'h18
`define LPE_BIT_TRANSIENT 62
`define LPE_BIT_RSVD_HI  51
`define LPE_BIT_ADDR_LO  12
`define LPE_BIT_FORCE_COH 11
`define LPE_BIT_SKIP_ATTR 6
`define LPE_BIT_MTYPE_HI 5
`define LPE_BIT_MTYPE_LO 3
`define LPE_BIT_WR       1
`define LPE_BIT_RD       0
`define LPE_CFG_DEVTLB   0
`define LPE_CFG_COHCTL   1
`define LPE_CFG_MTYPE_EN 2
`define LPE_CFG_COH      3
`define LPE_REQ_XLAT     0
`define LPE_REQ_PASID    1
`define LPE_REQ_NESTED   2
`define LPE_REQ_WR       3
`define LPE_REQ_RD       4
`define LPE_REQ_NS       5
`define LPE_CFG_RST      4'h0
`define LPE_REQ_RST      6'h00
`define LPE_MTYPE_UC     3'h0
`define LPE_MTYPE_WC     3'h1
`define LPE_MTYPE_WT     3'h4
`define LPE_MTYPE_WP     3'h5
`define LPE_MTYPE_WB     3'h6
`endif

// ==== include/lpe_pkg.sv ====
// types of the leaf page entry decoder
// assumes nothing beyond lpe_map.svh for numbers
package lpe_pkg;
    typedef enum logic [2:0] {
        LPE_MT_UC,
        LPE_MT_WC,
        LPE_MT_WT,
        LPE_MT_WP,
        LPE_MT_WB,
        LPE_MT_RSVD
    } lpe_memtype_e;
endpackage : lpe_pkg

// ==== include/lpe_fields_if.sv ====
// decoded fields of one leaf entry, passed from the splitter to its users
// assumes all parties share one clock; the contents are combinational
`timescale 1ns/1ps
interface lpe_fields_if #(parameter int host_addr_width_param = 48);
    logic [host_addr_width_param-13:0] pageFrame;
    logic            transientMapFlag;
    logic            forceCacheCoherentFlag;
    logic            skipAttrTableFlag;
    logic [2:0]      extMemoryTypeField;
    logic            wrPerm;
    logic            rdPerm;
    logic            rsvdFault;
    modport split (output pageFrame, transientMapFlag, forceCacheCoherentFlag,
                   skipAttrTableFlag, extMemoryTypeField, wrPerm, rdPerm, rsvdFault);
    modport user  (input pageFrame, transientMapFlag, forceCacheCoherentFlag,
                   skipAttrTableFlag, extMemoryTypeField, wrPerm, rdPerm, rsvdFault);
endinterface : lpe_fields_if

// ==== logic/lpe_field_split.sv ====
// splits a 64-bit leaf entry into its fields and checks reserved bits
// assumes capability bits are stable while an entry is evaluated
`timescale 1ns/1ps
`include "lpe_map.svh"
module lpe_field_split #(
    parameter int host_addr_width_param = 48
) (
    input  wire logic [63:0] entry,      // raw leaf entry
    input  wire logic        devTlbSup,  // device_tlb_supported
    input  wire logic        cohCtlSup,  // coherency_control_supported
    lpe_fields_if.split      fld         // decoded fields
);
    logic transientRaw;
    logic forceCohRaw;
    logic highRsvd;
    // bits 63, 61:52 and 10:7 are never picked up here
    assign transientRaw = entry[`LPE_BIT_TRANSIENT];
    assign forceCohRaw  = entry[`LPE_BIT_FORCE_COH];
    assign highRsvd     = |entry[`LPE_BIT_RSVD_HI:host_addr_width_param];
    assign fld.pageFrame = entry[host_addr_width_param-1:`LPE_BIT_ADDR_LO];
    // reserved copies read as zero so no stale flag leaks into completions
    assign fld.transientMapFlag       = transientRaw & devTlbSup;
    assign fld.forceCacheCoherentFlag = forceCohRaw & cohCtlSup;
    assign fld.skipAttrTableFlag      = entry[`LPE_BIT_SKIP_ATTR];
    assign fld.extMemoryTypeField     = entry[`LPE_BIT_MTYPE_HI:`LPE_BIT_MTYPE_LO];
    assign fld.wrPerm = entry[`LPE_BIT_WR];
    assign fld.rdPerm = entry[`LPE_BIT_RD];
    assign fld.rsvdFault = (transientRaw & ~devTlbSup)
                         | (forceCohRaw & ~cohCtlSup)
                         | highRsvd;
endmodule : lpe_field_split

// ==== logic/lpe_memtype.sv ====
// memory type selection for nested PASID requests
// assumes the caller merges the attribute table when attrTableUsed is high
`timescale 1ns/1ps
`include "lpe_map.svh"
module lpe_memtype (
    lpe_fields_if.user          fld,          // decoded fields
    input  wire logic           memTypeEnable, // ext_memtype_enable
    input  wire logic           cohDomain,    // device in coherency domain
    input  wire logic           nested,       // nested translation
    input  wire logic           pasid,        // request carries a PASID
    output lpe_pkg::lpe_memtype_e memType,    // decoded type
    output logic                memTypeValid, // type applies to this request
    output logic                attrTableUsed // attribute table joins in
);
    logic applies;
    assign applies       = memTypeEnable & cohDomain & nested & pasid;
    assign memTypeValid  = applies;
    assign attrTableUsed = applies & ~fld.skipAttrTableFlag;
    always_comb begin
        case (fld.extMemoryTypeField)
            `LPE_MTYPE_UC: memType = lpe_pkg::LPE_MT_UC;
            `LPE_MTYPE_WC: memType = lpe_pkg::LPE_MT_WC;
            `LPE_MTYPE_WT: memType = lpe_pkg::LPE_MT_WT;
            `LPE_MTYPE_WP: memType = lpe_pkg::LPE_MT_WP;
            `LPE_MTYPE_WB: memType = lpe_pkg::LPE_MT_WB;
            default:     memType = lpe_pkg::LPE_MT_RSVD;
        endcase
    end
endmodule : lpe_memtype

// ==== logic/lpe_leaf_decode.sv ====
// register front end and request evaluation for a 4-KByte leaf entry
// assumes a single-cycle strobe master; reads answer one cycle later
//
// The register addresses and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
`include "lpe_map.svh"
module lpe_leaf_decode #(
    parameter int host_addr_width_param = 48
) (
    input  wire logic        clk,           // 25 MHz clock
    input  wire logic        rst,           // async reset, active high
    input  wire logic [7:0]  regAddr,       // byte offset
    input  wire logic [31:0] regWrData,     // write data
    input  wire logic        regWr,         // write strobe
    input  wire logic        regRd,         // read strobe
    output logic      [31:0] regRdData,     // read data, cycle after strobe
    output logic [host_addr_width_param-13:0] pageFrame, // translated page frame
    output logic             resultValid,   // result latched, sticky until status read
    output logic             complUntrans,  // completion U field
    output logic             complNoSnoop,  // completion N field
    output logic             snoopForced,   // untranslated access snoops caches
    output logic             writeDenied,   // write refused
    output logic             readDenied,    // read refused
    output logic             reservedFault, // reserved bit set in entry
    output lpe_pkg::lpe_memtype_e memType,  // extended memory type
    output logic             memTypeValid,  // memType applies
    output logic             attrTableUsed  // attribute table joins in
);
    localparam int PFW = host_addr_width_param - 12;

    // software-visible state and the evaluation-pending flag
    logic [31:0] entryLo;
    logic [31:0] entryHi;
    logic [3:0]  cfg;
    logic [5:0]  req;
    logic        evalPending;
    logic [31:0] next_entryLo;
    logic [31:0] next_entryHi;
    logic [3:0]  next_cfg;
    logic [5:0]  next_req;
    logic        next_evalPending;

    // latched results
    logic [PFW-1:0] next_pageFrame;
    logic           next_resultValid;
    logic           next_complUntrans;
    logic           next_complNoSnoop;
    logic           next_snoopForced;
    logic           next_writeDenied;
    logic           next_readDenied;
    logic           next_reservedFault;
    lpe_pkg::lpe_memtype_e next_memType;
    logic           next_memTypeValid;
    logic           next_attrTableUsed;
    logic [31:0]    next_regRdData;

    // combinational evaluation
    lpe_pkg::lpe_memtype_e mtComb;
    logic           mtValidComb;
    logic           attrComb;
    logic           isXlat;
    logic           hasPasid;
    logic           nsAttr;
    logic           evalU;
    logic           evalN;
    logic           evalSnoop;
    logic [63:0]    physAddr;
    logic [31:0]    statusWord;

    lpe_fields_if #(.host_addr_width_param(host_addr_width_param)) fld ();

    lpe_field_split #(
        .host_addr_width_param (host_addr_width_param)
    ) uSplit (
        .entry     ({entryHi, entryLo}),
        .devTlbSup (cfg[`LPE_CFG_DEVTLB]),
        .cohCtlSup (cfg[`LPE_CFG_COHCTL]),
        .fld       (fld)
    );

    lpe_memtype uMemType (
        .fld          (fld),
        .memTypeEnable (cfg[`LPE_CFG_MTYPE_EN]),
        .cohDomain    (cfg[`LPE_CFG_COH]),
        .nested       (req[`LPE_REQ_NESTED]),
        .pasid        (req[`LPE_REQ_PASID]),
        .memType      (mtComb),
        .memTypeValid (mtValidComb),
        .attrTableUsed (attrComb)
    );

    assign isXlat   = req[`LPE_REQ_XLAT];
    assign hasPasid = req[`LPE_REQ_PASID];
    assign nsAttr   = req[`LPE_REQ_NS];

    // completion fields; zero for untranslated requests
    always_comb begin
        evalU = 1'b0;
        evalN = 1'b0;
        evalSnoop = 1'b0;
        if (isXlat) begin
            evalU = fld.transientMapFlag;
            if (hasPasid) begin
                evalN = 1'b1;
            end else begin
                evalN = fld.forceCacheCoherentFlag;
            end
        end else begin
            if (hasPasid) begin
                evalSnoop = 1'b1;
            end else begin
                // the request's no-snoop hint only counts when the entry leaves it alone
                evalSnoop = fld.forceCacheCoherentFlag | ~nsAttr;
            end
        end
    end

    assign physAddr = {{(64 - host_addr_width_param){1'b0}}, pageFrame, 12'h000};

    assign statusWord = {20'h00000,
                         memTypeValid,
                         memType,
                         attrTableUsed,
                         complNoSnoop,
                         complUntrans,
                         snoopForced,
                         reservedFault,
                         readDenied,
                         writeDenied,
                         resultValid};

    // register writes and request launch
    always_comb begin
        next_entryLo     = entryLo;
        next_entryHi     = entryHi;
        next_cfg         = cfg;
        next_req         = req;
        next_evalPending = 1'b0;
        if (regWr) begin
            case (regAddr)
                `LPE_REG_ENTRY_LO: next_entryLo = regWrData;
                `LPE_REG_ENTRY_HI: next_entryHi = regWrData;
                `LPE_REG_CONFIG:   next_cfg = regWrData[3:0];
                `LPE_REG_REQUEST: begin
                    next_req = regWrData[5:0];
                    next_evalPending = 1'b1;
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            entryLo     <= 32'h00000000;
            entryHi     <= 32'h00000000;
            cfg         <= `LPE_CFG_RST;
            req         <= `LPE_REQ_RST;
            evalPending <= 1'b0;
        end else begin
            entryLo     <= next_entryLo;
            entryHi     <= next_entryHi;
            cfg         <= next_cfg;
            req         <= next_req;
            evalPending <= next_evalPending;
        end
    end

    // results latch one cycle after the request register settles
    always_comb begin
        next_pageFrame     = pageFrame;
        next_complUntrans  = complUntrans;
        next_complNoSnoop  = complNoSnoop;
        next_snoopForced   = snoopForced;
        next_writeDenied   = writeDenied;
        next_readDenied    = readDenied;
        next_reservedFault = reservedFault;
        next_memType       = memType;
        next_memTypeValid  = memTypeValid;
        next_attrTableUsed = attrTableUsed;
        next_resultValid   = resultValid;
        if (regRd && regAddr == `LPE_REG_STATUS) begin
            next_resultValid = 1'b0;
        end
        // a fresh result wins over a status read in the same cycle
        if (evalPending) begin
            next_pageFrame     = fld.pageFrame;
            next_complUntrans  = evalU;
            next_complNoSnoop  = evalN;
            next_snoopForced   = evalSnoop;
            next_writeDenied   = req[`LPE_REQ_WR] & ~fld.wrPerm;
            next_readDenied    = req[`LPE_REQ_RD] & ~fld.rdPerm;
            next_reservedFault = fld.rsvdFault;
            next_memType       = mtComb;
            next_memTypeValid  = mtValidComb;
            next_attrTableUsed = attrComb;
            next_resultValid   = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pageFrame     <= '0;
            complUntrans  <= 1'b0;
            complNoSnoop  <= 1'b0;
            snoopForced   <= 1'b0;
            writeDenied   <= 1'b0;
            readDenied    <= 1'b0;
            reservedFault <= 1'b0;
            memType       <= lpe_pkg::LPE_MT_UC;
            memTypeValid  <= 1'b0;
            attrTableUsed <= 1'b0;
            resultValid   <= 1'b0;
        end else begin
            pageFrame     <= next_pageFrame;
            complUntrans  <= next_complUntrans;
            complNoSnoop  <= next_complNoSnoop;
            snoopForced   <= next_snoopForced;
            writeDenied   <= next_writeDenied;
            readDenied    <= next_readDenied;
            reservedFault <= next_reservedFault;
            memType       <= next_memType;
            memTypeValid  <= next_memTypeValid;
            attrTableUsed <= next_attrTableUsed;
            resultValid   <= next_resultValid;
        end
    end

    // read data stand for exactly one cycle, zero otherwise
    always_comb begin
        next_regRdData = 32'h00000000;
        if (regRd) begin
            case (regAddr)
                `LPE_REG_ENTRY_LO: next_regRdData = entryLo;
                `LPE_REG_ENTRY_HI: next_regRdData = entryHi;
                `LPE_REG_CONFIG:   next_regRdData = {28'h0000000, cfg};
                `LPE_REG_REQUEST:  next_regRdData = {26'h0, req};
                `LPE_REG_STATUS:   next_regRdData = statusWord;
                `LPE_REG_PHYS_LO:  next_regRdData = physAddr[31:0];
                `LPE_REG_PHYS_HI:  next_regRdData = physAddr[63:32];
                default:           next_regRdData = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            regRdData <= 32'h00000000;
        end else begin
            regRdData <= next_regRdData;
        end
    end
endmodule : lpe_leaf_decode

// ==== testbench/lpe_leaf_decode_asserts.sv ====
// request-to-result assertions for the leaf entry decoder
// assumes the register map of lpe_map.svh and results two edges after a request
`timescale 1ns/1ps
`include "lpe_map.svh"
module lpe_leaf_decode_asserts #(
    parameter int host_addr_width_param = 48
) (
    input wire logic            clk,           // clock
    input wire logic            rst,           // async reset
    input wire logic [7:0]      regAddr,       // byte offset
    input wire logic [31:0]     regWrData,     // write data
    input wire logic            regWr,         // write strobe
    input wire logic [host_addr_width_param-13:0] pageFrame, // page frame
    input wire logic            complUntrans,  // U field
    input wire logic            complNoSnoop,  // N field
    input wire logic            snoopForced,   // snoop forced
    input wire logic            writeDenied,   // write refused
    input wire logic            readDenied,    // read refused
    input wire logic            reservedFault, // reserved bit set
    input wire logic [2:0]      memType,       // decoded memory type
    input wire logic            memTypeValid,  // memory type applies
    input wire logic            attrTableUsed  // table joins in
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic [31:0] entLo;
    logic [31:0] entHi;
    logic [3:0]  cfg;
    // shadow copies; the bench never rewrites them while a result is pending
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            entLo <= 32'h0;
            entHi <= 32'h0;
            cfg   <= 4'h0;
        end else if (regWr) begin
            if (regAddr == `LPE_REG_ENTRY_LO) entLo <= regWrData;
            if (regAddr == `LPE_REG_ENTRY_HI) entHi <= regWrData;
            if (regAddr == `LPE_REG_CONFIG) cfg <= regWrData[3:0];
        end
    end
    wire [63:0] ent    = {entHi, entLo};
    wire        isReq  = regWr && (regAddr == `LPE_REG_REQUEST);
    wire        xl     = regWrData[`LPE_REQ_XLAT];
    wire        pa     = regWrData[`LPE_REQ_PASID];
    wire        forceCoh = ent[`LPE_BIT_FORCE_COH] & cfg[`LPE_CFG_COHCTL];
    wire        rsvdHi = |(ent[51:0] >> host_addr_width_param);
    wire [2:0]  mtCode = ent[5:3];

    a_frame_copy: assert property (isReq |-> ##2
        pageFrame == ent[host_addr_width_param-1:12])
        else $error("page frame not taken from entry");
    a_mtype_decode: assert property (isReq |-> ##2 memType ==
        ((mtCode == 3'h0) ? 3'h0 : (mtCode == 3'h1) ? 3'h1 : (mtCode == 3'h4) ? 3'h2 :
         (mtCode == 3'h5) ? 3'h3 : (mtCode == 3'h6) ? 3'h4 : 3'h5))
        else $error("memory type decode wrong");
    a_u_field: assert property (isReq && xl |-> ##2 complUntrans == (ent[62] & cfg[0]))
        else $error("completion U field wrong");
    a_rsvd_check: assert property (isReq |-> ##2
        reservedFault == ((ent[62] & !cfg[0]) | (ent[11] & !cfg[1]) | rsvdHi))
        else $error("reserved fault wrong");
    a_snoop_override: assert property (isReq && !xl && !pa && regWrData[5] |-> ##2
        snoopForced == forceCoh)
        else $error("snoop override not applied");
    a_nsnoop_copy: assert property (isReq && xl && !pa |-> ##2
        complNoSnoop == forceCoh && !snoopForced)
        else $error("completion N field wrong");
    a_pasid_snoop: assert property (isReq && !xl && pa |-> ##2 snoopForced && !complNoSnoop)
        else $error("pasid access not snooped");
    a_pasid_nsnoop: assert property (isReq && xl && pa |-> ##2 complNoSnoop && !snoopForced)
        else $error("pasid completion N not set");
    a_wr_deny: assert property (isReq && regWrData[3] |-> ##2 writeDenied == !ent[1])
        else $error("write permission wrong");
    a_rd_deny: assert property (isReq && regWrData[4] |-> ##2 readDenied == !ent[0])
        else $error("read permission wrong");
    a_type_gate: assert property (isReq && pa && regWrData[2] |-> ##2
        memTypeValid == (cfg[2] & cfg[3]) && attrTableUsed == (cfg[2] & cfg[3] & !ent[6]))
        else $error("memory type gating wrong");
    a_type_class: assert property (isReq && !(pa && regWrData[2]) |-> ##2
        !memTypeValid && !attrTableUsed)
        else $error("memory type outside nested pasid");
endmodule : lpe_leaf_decode_asserts

bind lpe_leaf_decode lpe_leaf_decode_asserts #(.host_addr_width_param(host_addr_width_param))
    lpe_leaf_decode_asserts_inst (
    .clk(clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
    .pageFrame(pageFrame), .complUntrans(complUntrans), .complNoSnoop(complNoSnoop),
    .snoopForced(snoopForced), .writeDenied(writeDenied), .readDenied(readDenied),
    .reservedFault(reservedFault), .memType(memType), .memTypeValid(memTypeValid),
    .attrTableUsed(attrTableUsed)
);

// ==== testbench/lpe_page_table_model.sv ====
// page table model: hands the bench one leaf entry per index
// assumes a host address width below 52 so that a reserved address bit exists
`timescale 1ns/1ps
module lpe_page_table_model #(
    parameter int host_addr_width_param = 48
) (
    input  wire logic [2:0] idx,       // entry choice
    input  wire logic       breakRsvd, // set a reserved address bit
    output logic     [63:0] entry      // leaf entry
);
    always_comb begin
        entry = 64'h0;
        entry[63] = 1'b1;
        entry[62] = idx[0];
        entry[61:52] = 10'h2A5;
        entry[host_addr_width_param-1:12] = ~(host_addr_width_param-12)'(idx);
        entry[11] = idx[1];
        entry[10:7] = 4'hA;
        entry[6] = idx[2];
        entry[5:3] = idx;
        entry[1] = idx[0] ^ idx[1];
        entry[0] = ~idx[2];
        entry[host_addr_width_param] = breakRsvd;
    end
endmodule : lpe_page_table_model

// ==== testbench/tb_top.sv ====
// self-checking bench for the leaf entry decoder
// assumes the register map of lpe_map.svh and the default address width
`timescale 1ns/1ps
`include "lpe_map.svh"
module tb_top;
    localparam int host_addr_width_param = 48;
    logic            clk;
    logic            rst;
    logic [7:0]      regAddr;
    logic [31:0]     regWrData;
    logic            regWr;
    logic            regRd;
    logic [31:0]     regRdData;
    logic [host_addr_width_param-13:0] pageFrame;
    logic [2:0]      idx;
    logic            breakRsvd;
    logic [63:0]     entry;
    int              fail_count;
    int              comparisons;

    lpe_leaf_decode #(.host_addr_width_param(host_addr_width_param)) lpe_leaf_decode_inst (
        .clk(clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
        .regRd(regRd), .regRdData(regRdData), .pageFrame(pageFrame), .resultValid(),
        .complUntrans(), .complNoSnoop(), .snoopForced(), .writeDenied(), .readDenied(),
        .reservedFault(), .memType(), .memTypeValid(), .attrTableUsed()
    );
    lpe_page_table_model #(
        .host_addr_width_param(host_addr_width_param)
    ) lpe_page_table_model_inst (
        .idx(idx), .breakRsvd(breakRsvd), .entry(entry)
    );

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        regAddr   <= a;
        regWrData <= d;
        regWr     <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        regAddr <= a;
        regRd   <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        // data stand only in this cycle; take them mid-cycle, clear of the next edge
        @(negedge clk);
        d = regRdData;
    endtask : rd
    task automatic results();
        $display("comparisons %0d, mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : results
    // status word as the rules predict it
    function automatic logic [11:0] expStat(input logic [63:0] e, input logic [3:0] c,
                                            input logic [5:0] q);
        logic [11:0] s;
        logic        forceCoh;
        logic        mtv;
        s    = 12'h001;
        forceCoh = e[11] & c[1];
        mtv  = c[2] & c[3] & q[2] & q[1];
        s[1] = q[3] & ~e[1];
        s[2] = q[4] & ~e[0];
        s[3] = (e[62] & ~c[0]) | (e[11] & ~c[1]) | (|(e[51:0] >> host_addr_width_param));
        s[4] = ~q[0] & (q[1] | forceCoh | ~q[5]);
        s[5] = q[0] & e[62] & c[0];
        s[6] = q[0] & (q[1] | forceCoh);
        s[7] = mtv & ~e[6];
        case (e[5:3])
            3'h0: s[10:8] = 3'h0;
            3'h1: s[10:8] = 3'h1;
            3'h4: s[10:8] = 3'h2;
            3'h5: s[10:8] = 3'h3;
            3'h6: s[10:8] = 3'h4;
            default: s[10:8] = 3'h5;
        endcase
        s[11] = mtv;
        return s;
    endfunction : expStat

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        repeat (60000) @(posedge clk);
        fail_count++;
        results();
    end
    initial begin
        logic [31:0] rv;
        logic [11:0] st;
        logic [3:0]  c;
        logic [5:0]  q;
        rst = 1'b1;
        regAddr = 8'h00;
        regWrData = 32'h0;
        regWr = 1'b0;
        regRd = 1'b0;
        idx = 3'h0;
        breakRsvd = 1'b0;
        fail_count = 0;
        comparisons = 0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        rd(`LPE_REG_STATUS, rv);
        chk(rv, 64'h0);
        rd(8'h40, rv);
        chk(rv, 64'h0);
        // every config against every request, entries cycling all memory type codes
        for (int n = 0; n < 1024; n++) begin
            c = n[9:6];
            q = n[5:0];
            idx <= q[2:0] ^ c[2:0];
            breakRsvd <= c[3] & q[3];
            wr(`LPE_REG_CONFIG, {28'h0, c});
            wr(`LPE_REG_ENTRY_LO, entry[31:0]);
            wr(`LPE_REG_ENTRY_HI, entry[63:32]);
            wr(`LPE_REG_REQUEST, {26'h0, q});
            @(posedge clk);
            st = expStat(entry, c, q);
            rd(`LPE_REG_STATUS, rv);
            chk(rv[6:0], st[6:0]);
            chk(rv[11:7], st[11:7]);
            rd(`LPE_REG_STATUS, rv);
            chk(rv[11:0], {st[11:1], 1'b0});
            chk(pageFrame, entry[host_addr_width_param-1:12]);
            rd(`LPE_REG_PHYS_LO, rv);
            chk(rv, {entry[31:12], 12'h000});
            rd(`LPE_REG_PHYS_HI, rv);
            chk(rv, 64'(entry[host_addr_width_param-1:32]));
        end
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd(`LPE_REG_STATUS, rv);
        chk(rv, 64'h0);
        chk(pageFrame, 64'h0);
        results();
    end
endmodule : tb_top
